// ### verilog/emb_defines.vh
// constants for the external memory bus access sequencer
//
// How it works
// R01 - every access starts on a bus clock rising edge; insert an alignment cycle otherwise
// R02 - alignment cycles keep all strobes and controls inactive
// R03 - with ready_use_enable at 0 the ready pin is ignored completely
// R04 - the address bus holds the last address between accesses and during alignment
// R05 - synchronous ready: first sample at lead plus active cycles from access start
// R06 - asynchronous ready: first sample two cycles before lead plus active
// R07 - ready high at a sample ends the active phase; low resamples every timing cycle
// R08 - zone select falls on a bus clock rising edge at access start
// R09 - a valid address is placed on a bus clock rising edge at access start
// R10 - for a write, read_not_write falls at access start and rises at its end
// R11 - read strobe falls at active start and rises at trail start
// R12 - write data is driven from write strobe low through the trail phase
// R13 - the data bus is released once read_not_write is back high
// R14 - zone select rises at the end of the access
// R15 - write strobe falls at active start and rises at trail start
// R16 - phases are counted in timing clock cycles; strobes change on its edges
// R17 - at half-rate bus clock even counts align to rising, odd to falling edges
// R18 - ready_sampling_mode 0 selects synchronous, 1 asynchronous ready sampling
// R19 - lead is at least one cycle; active and trail may be zero
`ifndef EMB_DEFINES_VH
`define EMB_DEFINES_VH

// register offsets (byte addresses)
`define EMB_OFS_CFG        4'h0
`define EMB_OFS_STATUS     4'h4
`define EMB_OFS_RDATA      4'h8
`define EMB_OFS_ADDR       4'hc

// configuration fields
`define EMB_CFG_RD_LEAD    1:0
`define EMB_CFG_RD_ACT     4:2
`define EMB_CFG_RD_TRAIL   6:5
`define EMB_CFG_WR_LEAD    8:7
`define EMB_CFG_WR_ACT     11:9
`define EMB_CFG_WR_TRAIL   13:12
`define EMB_CFG_USE_RDY    14
`define EMB_CFG_RDY_MODE   15
`define EMB_CFG_DOUBLER    16
`define EMB_CFG_CLK_HALF   17
`define EMB_CFG_RST        32'h0000_3fff

// timing clock divider: core cycles per timing clock cycle
`define EMB_TIM_DIV        2

// sequencer states
`define EMB_ST_IDLE        3'h0
`define EMB_ST_ALIGN       3'h1
`define EMB_ST_LEAD        3'h2
`define EMB_ST_ACT         3'h3
`define EMB_ST_TRAIL       3'h4

`endif

// ### verilog/emb_buf2.v
// two-entry request buffer with valid/ready on both sides
module emb_buf2 #(
   parameter W = 36
) (
   // clock and reset
   input  wire         core_clk_i,
   input  wire         rst_n_i,
   // fill side
   input  wire         in_valid_i,
   output wire         in_ready_o,
   input  wire [W-1:0] in_data_i,
   // drain side
   output wire         out_valid_o,
   input  wire         out_ready_i,
   output wire [W-1:0] out_data_o
);
   reg [W-1:0] ent0_q;
   reg [W-1:0] ent1_q;
   reg         wptr_q;
   reg         rptr_q;
   reg [1:0]   cnt_q;

   wire push = in_valid_i & in_ready_o;
   wire pop  = out_valid_o & out_ready_i;

   assign in_ready_o  = (cnt_q != 2'h2);
   assign out_valid_o = (cnt_q != 2'h0);
   assign out_data_o  = rptr_q ? ent1_q : ent0_q;

   always @(posedge core_clk_i)
   begin
      if (!rst_n_i)
      begin
         ent0_q <= {W{1'b0}};
         ent1_q <= {W{1'b0}};
         wptr_q <= 1'b0;
         rptr_q <= 1'b0;
         cnt_q  <= 2'h0;
      end
      else
      begin
         if (push)
         begin
            if (wptr_q)
               ent1_q <= in_data_i;
            else
               ent0_q <= in_data_i;
            wptr_q <= ~wptr_q;
         end
         if (pop)
            rptr_q <= ~rptr_q;
         if (push && !pop)
            cnt_q <= cnt_q + 2'h1;
         else if (pop && !push)
            cnt_q <= cnt_q - 2'h1;
      end
   end
endmodule

// ### verilog/emb_sequencer.v
// external memory bus access sequencer: lead/active/trail timing, ready, bus clock
//
// The plain strobed port and the address map were left to the implementer.
`include "emb_defines.vh"

module emb_sequencer #(
   parameter AW      = 19,
   parameter DW      = 16,
   parameter TIM_DIV = `EMB_TIM_DIV
) (
   // clock and reset
   input  wire          core_clk_i,
   input  wire          rst_n_i,
   // register port
   input  wire [3:0]    reg_addr_i,
   input  wire [31:0]   reg_wdata_i,
   input  wire          reg_wr_i,
   input  wire          reg_rd_i,
   output reg  [31:0]   reg_rdata_o,
   // access requests
   input  wire          req_valid_i,
   output wire          req_ready_o,
   input  wire          req_write_i,
   input  wire [AW-1:0] req_addr_i,
   input  wire [DW-1:0] req_wdata_i,
   // read results
   output reg           rsp_valid_o,
   output reg  [DW-1:0] rsp_data_o,
   // external bus pins
   output reg           ext_bus_clock_out_o,
   output reg           zone_select_n_o,
   output reg           read_strobe_n_o,
   output reg           write_strobe_n_o,
   output reg           read_not_write_o,
   output reg  [AW-1:0] ext_address_bus_o,
   output reg  [DW-1:0] ext_data_bus_o,
   output reg           ext_data_bus_oe_o,
   input  wire [DW-1:0] ext_data_bus_i,
   input  wire          ext_ready_in_i
);
   localparam BW = 1 + AW + DW;

   // configuration
   reg  [31:0]   cfg_q;
   wire          use_rdy   = cfg_q[`EMB_CFG_USE_RDY];
   wire          rdy_async = cfg_q[`EMB_CFG_RDY_MODE];
   wire          dbl       = cfg_q[`EMB_CFG_DOUBLER];
   wire          clk_half  = cfg_q[`EMB_CFG_CLK_HALF];

   // timing clock enable and bus clock
   reg  [7:0]    div_q;
   reg           half_q;
   wire          tick   = (div_q == TIM_DIV - 1);
   wire [7:0]    div_d  = tick ? 8'h00 : div_q + 8'h01;
   wire          half_d = half_q ^ tick;

   // pin synchronisers
   reg           rdy_s1_q;
   reg           rdy_s2_q;
   reg  [DW-1:0] dat_s1_q;
   reg  [DW-1:0] dat_s2_q;
   reg           hist1_q;
   reg           hist2_q;

   // sequencer
   reg  [2:0]    state_q;
   reg  [7:0]    el_q;
   reg  [7:0]    trail_end_q;
   reg           cur_wr_q;
   reg  [AW-1:0] cur_addr_q;
   reg  [DW-1:0] cur_data_q;
   reg           rd_cap_q;

   // request buffer
   wire          buf_valid;
   wire [BW-1:0] buf_data;
   wire          buf_wr   = buf_data[BW-1];
   wire [AW-1:0] buf_addr = buf_data[BW-2:DW];
   wire [DW-1:0] buf_wdat = buf_data[DW-1:0];
   wire          pop = tick & buf_valid & (state_q == `EMB_ST_IDLE);

   emb_buf2 #(
      .W (BW)
   ) u_req_buf (
      .core_clk_i  (core_clk_i),
      .rst_n_i     (rst_n_i),
      .in_valid_i  (req_valid_i),
      .in_ready_o  (req_ready_o),
      .in_data_i   ({req_write_i, req_addr_i, req_wdata_i}),
      .out_valid_o (buf_valid),
      .out_ready_i (pop),
      .out_data_o  (buf_data)
   );

   // phase lengths of the access in flight
   wire [1:0] f_lead = cur_wr_q ? cfg_q[`EMB_CFG_WR_LEAD]  : cfg_q[`EMB_CFG_RD_LEAD];
   wire [2:0] f_act  = cur_wr_q ? cfg_q[`EMB_CFG_WR_ACT]   : cfg_q[`EMB_CFG_RD_ACT];
   wire [1:0] f_trl  = cur_wr_q ? cfg_q[`EMB_CFG_WR_TRAIL] : cfg_q[`EMB_CFG_RD_TRAIL];
   wire [1:0] lead_b = (f_lead == 2'h0) ? 2'h1 : f_lead; // R19
   wire [7:0] lead_n = dbl ? {5'h00, lead_b, 1'b0} : {6'h00, lead_b};
   wire [7:0] act_n  = dbl ? {4'h0, f_act, 1'b0}   : {5'h00, f_act};
   wire [7:0] trl_n  = dbl ? {5'h00, f_trl, 1'b0}  : {6'h00, f_trl};
   wire [7:0] la_n   = lead_n + act_n;

   // cycles of the access completed after this tick, saturating during long waits
   wire [7:0] p = (el_q == 8'hff) ? 8'hff : el_q + 8'h01; // R16

   // async samples are taken two timing cycles ahead of the decision point
   wire rdy_smp  = rdy_async ? hist2_q : rdy_s2_q; // R05 R06 R18
   wire rdy_ok   = ~use_rdy | rdy_smp; // R03 R07
   wire lead_done = (p >= lead_n);
   wire act_done  = lead_done & (p >= la_n) & rdy_ok;

   // next timing cycle is even, so its start is a bus clock rising edge
   wire aligned = ~clk_half | half_q; // R17
   wire start   = tick & (((state_q == `EMB_ST_IDLE) & buf_valid & aligned) |
                          (state_q == `EMB_ST_ALIGN)); // R01
   wire in_acc  = (state_q == `EMB_ST_LEAD) | (state_q == `EMB_ST_ACT) |
                  (state_q == `EMB_ST_TRAIL);

   // divider, bus clock and synchronisers
   always @(posedge core_clk_i)
   begin
      if (!rst_n_i)
      begin
         div_q               <= 8'h00;
         half_q              <= 1'b0;
         ext_bus_clock_out_o <= 1'b0;
         rdy_s1_q            <= 1'b0;
         rdy_s2_q            <= 1'b0;
         dat_s1_q            <= {DW{1'b0}};
         dat_s2_q            <= {DW{1'b0}};
         hist1_q             <= 1'b0;
         hist2_q             <= 1'b0;
      end
      else
      begin
         div_q  <= div_d;
         half_q <= half_d;
         // full rate: high in the first half of each timing cycle; half rate: even cycles
         if (clk_half)
            ext_bus_clock_out_o <= ~half_d; // R17
         else
            ext_bus_clock_out_o <= (div_d < TIM_DIV / 2); // R16
         rdy_s1_q <= ext_ready_in_i;
         rdy_s2_q <= rdy_s1_q;
         dat_s1_q <= ext_data_bus_i;
         dat_s2_q <= dat_s1_q;
         if (tick)
         begin
            hist1_q <= rdy_s2_q; // R07
            hist2_q <= hist1_q;
         end
      end
   end

   // access sequencer
   always @(posedge core_clk_i)
   begin
      if (!rst_n_i)
      begin
         state_q           <= `EMB_ST_IDLE;
         el_q              <= 8'h00;
         trail_end_q       <= 8'h00;
         cur_wr_q          <= 1'b0;
         cur_addr_q        <= {AW{1'b0}};
         cur_data_q        <= {DW{1'b0}};
         rd_cap_q          <= 1'b0;
         zone_select_n_o   <= 1'b1;
         read_strobe_n_o   <= 1'b1;
         write_strobe_n_o  <= 1'b1;
         read_not_write_o  <= 1'b1;
         ext_address_bus_o <= {AW{1'b0}};
         ext_data_bus_o    <= {DW{1'b0}};
         ext_data_bus_oe_o <= 1'b0;
         rsp_valid_o       <= 1'b0;
         rsp_data_o        <= {DW{1'b0}};
      end
      else
      begin
         // the synchronised bus lags the pin by two cycles, so the word is taken one cycle late
         rd_cap_q    <= 1'b0;
         rsp_valid_o <= rd_cap_q;
         if (rd_cap_q)
            rsp_data_o <= dat_s2_q;
         // release only after read_not_write is seen high, never in the same edge
         if (read_not_write_o)
            ext_data_bus_oe_o <= 1'b0; // R13
         if (pop)
         begin
            cur_wr_q   <= buf_wr;
            cur_addr_q <= buf_addr;
            cur_data_q <= buf_wdat;
         end
         if (start)
         begin
            state_q         <= `EMB_ST_LEAD;
            el_q            <= 8'h00;
            zone_select_n_o <= 1'b0; // R08
            if (state_q == `EMB_ST_IDLE)
            begin
               ext_address_bus_o <= buf_addr; // R09
               read_not_write_o  <= ~buf_wr; // R10
            end
            else
            begin
               ext_address_bus_o <= cur_addr_q; // R09
               read_not_write_o  <= ~cur_wr_q; // R10
            end
         end
         else if (tick)
         begin
            if (in_acc)
               el_q <= p;
            case (state_q)
               `EMB_ST_IDLE:
               begin
                  // strobes already inactive; the address bus is left alone
                  if (buf_valid)
                     state_q <= `EMB_ST_ALIGN; // R02 R04
               end
               `EMB_ST_LEAD, `EMB_ST_ACT:
               begin
                  if (act_done)
                  begin
                     read_strobe_n_o  <= 1'b1; // R11
                     write_strobe_n_o <= 1'b1; // R15
                     if (!cur_wr_q)
                        rd_cap_q <= 1'b1;
                     if (trl_n == 8'h00)
                     begin
                        state_q          <= `EMB_ST_IDLE;
                        zone_select_n_o  <= 1'b1; // R14
                        read_not_write_o <= 1'b1; // R10
                     end
                     else
                     begin
                        state_q     <= `EMB_ST_TRAIL;
                        trail_end_q <= p + trl_n;
                     end
                  end
                  else if (lead_done && state_q == `EMB_ST_LEAD)
                  begin
                     state_q <= `EMB_ST_ACT;
                     if (cur_wr_q)
                     begin
                        write_strobe_n_o  <= 1'b0; // R15
                        ext_data_bus_o    <= cur_data_q; // R12
                        ext_data_bus_oe_o <= 1'b1; // R12
                     end
                     else
                        read_strobe_n_o <= 1'b0; // R11
                  end
               end
               `EMB_ST_TRAIL:
               begin
                  // write data stays driven here until read_not_write rises
                  if (p >= trail_end_q)
                  begin
                     state_q          <= `EMB_ST_IDLE;
                     zone_select_n_o  <= 1'b1; // R14
                     read_not_write_o <= 1'b1; // R10
                  end
               end
               default:
                  state_q <= `EMB_ST_IDLE;
            endcase
         end
      end
   end

   // register port
   always @(posedge core_clk_i)
   begin
      if (!rst_n_i)
      begin
         cfg_q       <= `EMB_CFG_RST;
         reg_rdata_o <= 32'h0000_0000;
      end
      else
      begin
         if (reg_wr_i && reg_addr_i == `EMB_OFS_CFG)
            cfg_q <= reg_wdata_i;
         if (reg_rd_i)
         begin
            case (reg_addr_i)
               `EMB_OFS_CFG:
                  reg_rdata_o <= cfg_q;
               `EMB_OFS_STATUS:
                  reg_rdata_o <= {26'h0000000, req_ready_o, buf_valid, in_acc, state_q};
               `EMB_OFS_RDATA:
                  reg_rdata_o <= {{(32 - DW){1'b0}}, rsp_data_o};
               `EMB_OFS_ADDR:
                  reg_rdata_o <= {{(32 - AW){1'b0}}, ext_address_bus_o};
               default:
                  reg_rdata_o <= 32'h0000_0000;
            endcase
         end
         else
            reg_rdata_o <= 32'h0000_0000;
      end
   end
endmodule

// ### testbench/emb_seq_properties.sv
// pin relation checker for the access sequencer, bound to its top module
module emb_seq_chk #(
   parameter AW = 19,
   parameter DW = 16
) (
   // clock and reset
   input wire logic          core_clk_i,
   input wire logic          rst_n_i,
   // register and result side
   input wire logic          reg_rd_i,
   input wire logic [31:0]   reg_rdata_o,
   input wire logic          rsp_valid_o,
   // bus pins
   input wire logic          ext_bus_clock_out_o,
   input wire logic          zone_select_n_o,
   input wire logic          read_strobe_n_o,
   input wire logic          write_strobe_n_o,
   input wire logic          read_not_write_o,
   input wire logic [AW-1:0] ext_address_bus_o,
   input wire logic [DW-1:0] ext_data_bus_o,
   input wire logic          ext_data_bus_oe_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);

   zone_on_rise_a: assert property ($fell(zone_select_n_o) |->
      ext_bus_clock_out_o && !$past(ext_bus_clock_out_o)) else $error("zone fell off bus rise");
   addr_moves_start_a: assert property ($changed(ext_address_bus_o) |->
      $fell(zone_select_n_o)) else $error("address moved outside access start");
   idle_inactive_a: assert property (zone_select_n_o |->
      read_strobe_n_o && write_strobe_n_o) else $error("strobe active outside access");
   read_is_read_a: assert property (!read_strobe_n_o |->
      read_not_write_o && !zone_select_n_o) else $error("read strobe in wrong context");
   write_drives_a: assert property (!write_strobe_n_o |-> !read_not_write_o &&
      !zone_select_n_o && ext_data_bus_oe_o) else $error("write strobe without drive");
   bus_released_a: assert property (read_not_write_o && $past(read_not_write_o) |->
      !ext_data_bus_oe_o) else $error("data bus still driven");
   data_held_a: assert property (ext_data_bus_oe_o && $past(ext_data_bus_oe_o) |->
      $stable(ext_data_bus_o)) else $error("write data changed while driven");
   strobe_on_tick_a: assert property ($changed(read_strobe_n_o) |->
      $changed(ext_bus_clock_out_o)) else $error("strobe moved off a tick");
   rsp_in_read_a: assert property (rsp_valid_o |-> read_not_write_o &&
      $past(zone_select_n_o, 2) == 1'b0) else $error("result outside read access");
   rdata_one_a: assert property (reg_rdata_o != 32'h0 |-> $past(reg_rd_i))
      else $error("read data without read");
endmodule

bind emb_sequencer emb_seq_chk #(.AW(AW), .DW(DW)) i_chk (.core_clk_i, .rst_n_i,
   .reg_rd_i, .reg_rdata_o, .rsp_valid_o, .ext_bus_clock_out_o, .zone_select_n_o,
   .read_strobe_n_o, .write_strobe_n_o, .read_not_write_o, .ext_address_bus_o,
   .ext_data_bus_o, .ext_data_bus_oe_o);

// ### testbench/emb_mem_model.sv
// external memory model: small array, read drive, ready with programmable wait
module emb_mem_model (
   // clock
   input  wire logic        core_clk_i,
   // bus pins from the sequencer
   input  wire logic        zone_n_i,
   input  wire logic        rd_n_i,
   input  wire logic        we_n_i,
   input  wire logic [18:0] addr_i,
   input  wire logic [15:0] data_i,
   // answers
   output logic      [15:0] data_o,
   output logic             ready_o,
   // core cycles that ready stays low after zone select falls
   input  wire logic [7:0]  wait_i
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] mem [16];
   logic [15:0] last = 16'h0;
   logic [7:0]  cnt = 8'h0;
   wire         drv = !rd_n_i && !zone_n_i;

   always @(posedge core_clk_i)
   begin
      if (!we_n_i && !zone_n_i)
         mem[addr_i[3:0]] <= data_i;
      if (drv)
         last <= mem[addr_i[3:0]];
      cnt <= zone_n_i ? 8'h0 : (cnt == 8'hff ? cnt : cnt + 8'h1);
   end
   // released bus shows the inverse of the last word read, not the old word
   assign data_o  = drv ? mem[addr_i[3:0]] : ~last;
   assign ready_o = zone_n_i || cnt >= wait_i;
endmodule

// ### testbench/ext_memory_bus_access_sequencer_test.sv
// self-checking bench for the access sequencer
module ext_memory_bus_access_sequencer_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 0, rst_n = 0, wr = 0, rd = 0, rq_v = 0, rq_w = 0;
   logic [3:0] ra = 4'h0;
   logic [31:0] wd = 32'h0;
   logic [18:0] rq_a = 19'h0;
   logic [15:0] rq_d = 16'h0;
   logic [7:0] wait_cyc = 8'h0;
   wire [31:0] rdata;
   wire [18:0] xa;
   wire [15:0] rsp_d, xdo, xdi;
   wire rq_r, rsp_v, bclk, zn, rdn, wen, rnw, xoe, rdy;
   int err_count = 0, checks = 0, n;

   always #2 clk = ~clk;

   emb_sequencer i_dut (.core_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(ra),
      .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
      .req_valid_i(rq_v), .req_ready_o(rq_r), .req_write_i(rq_w), .req_addr_i(rq_a),
      .req_wdata_i(rq_d), .rsp_valid_o(rsp_v), .rsp_data_o(rsp_d),
      .ext_bus_clock_out_o(bclk), .zone_select_n_o(zn), .read_strobe_n_o(rdn),
      .write_strobe_n_o(wen), .read_not_write_o(rnw), .ext_address_bus_o(xa),
      .ext_data_bus_o(xdo), .ext_data_bus_oe_o(xoe), .ext_data_bus_i(xdi),
      .ext_ready_in_i(rdy));
   emb_mem_model i_mem (.core_clk_i(clk), .zone_n_i(zn), .rd_n_i(rdn), .we_n_i(wen),
      .addr_i(xa), .data_i(xdo), .data_o(xdi), .ready_o(rdy), .wait_i(wait_cyc));

   task automatic chk(input bit ok, input string m);
      checks++;
      if (!ok)
      begin
         err_count++;
         $display("CHECK FAILED at %0t: %s", $time, m);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d, mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic rw(input [3:0] a, input [31:0] d);
      @(posedge clk);
      ra <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rr(input [3:0] a, input [31:0] e);
      @(posedge clk);
      ra <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata === e, "register read");
   endtask
   task automatic send(input bit w, input [18:0] a, input [15:0] d);
      int i;
      @(posedge clk);
      rq_v <= 1'b1;
      rq_w <= w;
      rq_a <= a;
      rq_d <= d;
      for (i = 0; i < 200; i++)
      begin
         @(negedge clk);
         if (rq_r === 1'b1)
            break;
         @(posedge clk);
      end
      if (i == 200)
      begin
         chk(0, "request hang");
         report_and_stop();
      end
      @(posedge clk);
      rq_v <= 1'b0;
   endtask
   task automatic wait_rsp(input [15:0] e);
      int i;
      for (i = 0; i < 300 && rsp_v !== 1'b1; i++)
         @(posedge clk) #1;
      if (i == 300)
      begin
         chk(0, "result hang");
         report_and_stop();
      end
      chk(rsp_d === e, "read result");
      @(posedge clk) #1;
   endtask
   // zone-low length of the next access in core cycles
   task automatic measure(output int len);
      int i;
      len = 0;
      for (i = 0; i < 300 && zn !== 1'b0; i++) @(negedge clk);
      while (zn === 1'b0 && len < 400)
      begin
         len++;
         @(negedge clk);
      end
   endtask

   task automatic t_regs();
      rr(4'h0, 32'h0000_3fff);
      rw(4'h2, 32'hffff_ffff);
      rr(4'h2, 32'h0);
      rw(4'h0, 32'h0000_12a5);
      rr(4'h0, 32'h0000_12a5);
      $display("test regs done");
   endtask
   task automatic t_data();
      send(1, 19'h3, 16'ha5a5);
      send(1, 19'h4, 16'h5a5a);
      send(0, 19'h3, 16'h0);
      send(0, 19'h4, 16'h0);
      wait_rsp(16'ha5a5);
      wait_rsp(16'h5a5a);
      repeat (10) @(posedge clk);
      #1 chk(xa === 19'h4 && xoe === 1'b0, "address held, bus free");
      $display("test data done");
   endtask
   task automatic t_timing();
      // lead 0 must still last one cycle; the last entry doubles every count
      logic [31:0] cfg [9] = '{32'h12a5, 32'h1280, 32'h212a5, 32'h12ad,
         32'h52ad, 32'hd2ad, 32'h52ad, 32'hd2ad, 32'h112a5};
      logic [7:0] wt [9] = '{8'h0, 8'h0, 8'h0, 8'h3c, 8'h0, 8'h0, 8'h1e, 8'h1e, 8'h0};
      int ex [9] = '{6, 2, 6, 10, 10, 10, 0, 0, 12};
      for (int k = 0; k < 9; k++)
      begin
         rw(4'h0, cfg[k]);
         wait_cyc <= wt[k];
         send(0, 19'h3, 16'h0);
         measure(n);
         if (ex[k] != 0)
            chk(n == ex[k], "access length");
         else
            chk(n > 10 && n < 60, "ready wait length");
         repeat (8) @(posedge clk);
      end
      $display("test timing done");
   endtask

   initial
   begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      t_regs();
      t_data();
      t_timing();
      report_and_stop();
   end
endmodule
